// ---- hdl/rft_pkg.sv ----
// Package for the frame timer one block: register map, fields, reset values.
// Assumes an 8-bit register port with byte addresses as the device prints them.
package rft_pkg;
	localparam logic [7:0] ADDR_T0_CNT_LO   = 8'h13;
	localparam logic [7:0] ADDR_T1_CTRL     = 8'h14;
	localparam logic [7:0] ADDR_T1_RLD_HI   = 8'h15;
	localparam logic [7:0] ADDR_T1_RLD_LO   = 8'h16;
	localparam logic [7:0] ADDR_T1_CNT_HI   = 8'h17;
	localparam logic [7:0] ADDR_T1_CNT_LO   = 8'h18;
	localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h30;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h31;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h32;
	localparam int CTRL_STOP_RX_BIT  = 7;
	localparam int CTRL_START_HI     = 5;
	localparam int CTRL_START_LO     = 4;
	localparam int CTRL_RELOAD_BIT   = 3;
	localparam int CTRL_CLK_HI       = 1;
	localparam int CTRL_CLK_LO       = 0;
	localparam int TCTL_RUN_BIT      = 5;
	localparam int TCTL_MASK_BIT     = 1;
	localparam logic [7:0] CTRL_WR_MASK   = 8'hBB;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] RELOAD_RESET   = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam int RX_STOP_BITS = 4;
	localparam logic [2:0] RX_STOP_COUNT = 3'(RX_STOP_BITS);
	typedef enum logic [1:0] {
		RFT_START_NONE   = 2'b00,
		RFT_START_TX_END = 2'b01,
		RFT_START_LFO    = 2'b10,
		RFT_START_LFO_UF = 2'b11
	} rft_start_t;
	typedef enum logic [1:0] {
		RFT_CLK_FAST  = 2'b00,
		RFT_CLK_SLOW  = 2'b01,
		RFT_CLK_T0_UF = 2'b10,
		RFT_CLK_T2_UF = 2'b11
	} rft_clk_t;
endpackage

// ---- hdl/rft_timer_one.sv ----
// Frame timer one: 16-bit down counter with reload, auto start, receive stop,
// LOW_FREQUENCY_OSCILLATOR trimming gate, underflow interrupt and a byte-wide register port.
// Assumes all strobes and tick inputs are synchronous single-cycle pulses on clk_i.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module rft_timer_one
	import rft_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       tick_fast_i,
	input  wire logic       tick_slow_i,
	input  wire logic       t0_underflow_i,
	input  wire logic       t2_underflow_i,
	input  wire logic [7:0] t0_count_low_i,
	input  wire logic       tx_end_i,
	input  wire logic       rx_bit_i,
	input  wire logic       rx_frame_i,
	input  wire logic       lfo_i,
	output logic      [7:0] rdata_o,
	output logic            underflow_o,
	output logic            running_o,
	output logic            irq_o
);
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  rld_hi_q, rld_hi_d;
	logic [7:0]  rld_lo_q, rld_lo_d;
	logic [15:0] cnt_q, cnt_d;
	logic        run_q, run_d;
	logic        uf_q, uf_d;
	logic [2:0]  rxbits_q, rxbits_d;
	logic        rxstopped_q, rxstopped_d;
	logic        lfo_q, lfo_d;
	logic        sts_q, sts_d;
	logic        msk_q, msk_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        irq_q, irq_d;

	rft_start_t  start_sel;
	rft_clk_t    clk_sel;
	logic        lfo_mode;
	logic        tick;
	logic        start_ev;
	logic        stop_ev;
	logic        hit_zero;
	logic        lfo_rise;
	logic        sw_run_wr;

	assign start_sel = rft_start_t'(ctrl_q[CTRL_START_HI:CTRL_START_LO]);
	assign clk_sel   = rft_clk_t'(ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO]);
	assign lfo_mode  = ctrl_q[CTRL_START_HI];
	assign lfo_rise  = lfo_i & ~lfo_q;
	assign sw_run_wr = wr_i && addr_i == ADDR_TIMER_CTRL && wdata_i[TCTL_MASK_BIT];

	// Tick selection
	always_comb begin
		unique case (clk_sel)
			RFT_CLK_FAST:  tick = tick_fast_i;
			RFT_CLK_SLOW:  tick = tick_slow_i;
			RFT_CLK_T0_UF: tick = t0_underflow_i;
			RFT_CLK_T2_UF: tick = t2_underflow_i;
		endcase
	end

	// Start and stop events
	always_comb begin
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		unique case (start_sel)
			RFT_START_NONE:   start_ev = 1'b0;
			RFT_START_TX_END: start_ev = tx_end_i;
			RFT_START_LFO, RFT_START_LFO_UF: begin
				// One rising edge starts, the next stops: a gate of one LOW_FREQUENCY_OSCILLATOR period
				start_ev = lfo_rise & ~run_q;
				stop_ev  = lfo_rise & run_q;
			end
		endcase
		if (sw_run_wr) begin
			start_ev = wdata_i[TCTL_RUN_BIT];
			stop_ev  = ~wdata_i[TCTL_RUN_BIT];
		end
		// Receive stop only counts bits of a frame, ignored while trimming
		if (!lfo_mode && ctrl_q[CTRL_STOP_RX_BIT] && rxstopped_d && !rxstopped_q) begin
			stop_ev = 1'b1;
		end
	end

	// Receive bit counter
	always_comb begin
		rxbits_d    = rxbits_q;
		rxstopped_d = rxstopped_q;
		if (!rx_frame_i) begin
			rxbits_d    = 3'h0;
			rxstopped_d = 1'b0;
		end else if (rx_bit_i && rxbits_q != RX_STOP_COUNT) begin
			rxbits_d = rxbits_q + 3'h1;
			if (rxbits_d == RX_STOP_COUNT) begin
				rxstopped_d = 1'b1;
			end
		end
	end

	// Counter core
	always_comb begin
		cnt_d    = cnt_q;
		run_d    = run_q;
		uf_d     = 1'b0;
		hit_zero = run_q && tick && cnt_q == 16'h0000;
		if (start_ev) begin
			cnt_d = {rld_hi_q, rld_lo_q};
			run_d = 1'b1;
		end else if (stop_ev) begin
			run_d = 1'b0;
		end else if (hit_zero) begin
			// Trimming without underflow raises no flag at zero; stops there unless reload is set
			uf_d = (start_sel != RFT_START_LFO);
			if (ctrl_q[CTRL_RELOAD_BIT]) begin
				cnt_d = {rld_hi_q, rld_lo_q};
			end else begin
				run_d = 1'b0;
			end
		end else if (run_q && tick) begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	// Register port, interrupt
	always_comb begin
		ctrl_d   = ctrl_q;
		rld_hi_d = rld_hi_q;
		rld_lo_d = rld_lo_q;
		msk_d    = msk_q;
		sts_d    = sts_q;
		rdata_d  = 8'h00;
		lfo_d    = lfo_i;
		if (wr_i) begin
			unique case (addr_i)
				ADDR_T1_CTRL:   ctrl_d = wdata_i & CTRL_WR_MASK;
				ADDR_T1_RLD_HI: rld_hi_d = wdata_i;
				ADDR_T1_RLD_LO: rld_lo_d = wdata_i;
				ADDR_IRQ_MASK:  msk_d = wdata_i[0];
				default:        ;
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				ADDR_T0_CNT_LO:  rdata_d = t0_count_low_i;
				ADDR_T1_CTRL:    rdata_d = ctrl_q;
				ADDR_T1_RLD_HI:  rdata_d = rld_hi_q;
				ADDR_T1_RLD_LO:  rdata_d = rld_lo_q;
				ADDR_T1_CNT_HI:  rdata_d = cnt_q[15:8];
				ADDR_T1_CNT_LO:  rdata_d = cnt_q[7:0];
				ADDR_TIMER_CTRL: rdata_d = {2'b00, run_q, 5'b00000};
				ADDR_IRQ_STATUS: rdata_d = {7'h00, sts_q};
				ADDR_IRQ_MASK:   rdata_d = {7'h00, msk_q};
				default:         rdata_d = 8'h00;
			endcase
			if (addr_i == ADDR_IRQ_STATUS) begin
				sts_d = 1'b0;
			end
		end
		// Set wins over the read clear so no underflow is lost
		if (uf_d) begin
			sts_d = 1'b1;
		end
		irq_d = sts_d & msk_d;
	end

	// Software visible configuration
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q   <= CTRL_RESET;
			rld_hi_q <= RELOAD_RESET;
			rld_lo_q <= RELOAD_RESET;
			msk_q    <= IRQ_MASK_RESET[0];
		end else begin
			ctrl_q   <= ctrl_d;
			rld_hi_q <= rld_hi_d;
			rld_lo_q <= rld_lo_d;
			msk_q    <= msk_d;
		end
	end

	// Counter core
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
			uf_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			uf_q  <= uf_d;
		end
	end

	// Receive bit counter
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rxbits_q    <= 3'h0;
			rxstopped_q <= 1'b0;
		end else begin
			rxbits_q    <= rxbits_d;
			rxstopped_q <= rxstopped_d;
		end
	end

	// Previous oscillator level for edge detection
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lfo_q <= 1'b0;
		end else begin
			lfo_q <= lfo_d;
		end
	end

	// Read answer and interrupt
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sts_q   <= 1'b0;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
		end else begin
			sts_q   <= sts_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign rdata_o     = rdata_q;
	assign underflow_o = uf_q;
	assign running_o   = run_q;
	assign irq_o       = irq_q;
endmodule // rft_timer_one

// ---- test/rft_timer_one_monitor.sv ----
// Checker for frame timer one: read answer, run flag, underflow and interrupt.
// Assumes one clock domain; bound onto every instance of the timer.
`timescale 1ns/1ps
module rft_monitor
	import rft_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic       tick_fast_i,
	input wire logic       tick_slow_i,
	input wire logic       t0_underflow_i,
	input wire logic       t2_underflow_i,
	input wire logic       tx_end_i,
	input wire logic       rx_bit_i,
	input wire logic       lfo_i,
	input wire logic [7:0] rdata_o,
	input wire logic       underflow_o,
	input wire logic       running_o,
	input wire logic       irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire ctl_wr = wr_i && addr_i == ADDR_TIMER_CTRL && wdata_i[TCTL_MASK_BIT];
	wire any_ev = wr_i | rx_bit_i | lfo_i | tick_fast_i | tick_slow_i | t0_underflow_i
		| t2_underflow_i;
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_sw_start: assert property (ctl_wr && wdata_i[TCTL_RUN_BIT] |=> running_o)
		else $error("start ignored");
	a_sw_stop: assert property (ctl_wr && !wdata_i[TCTL_RUN_BIT] |=> !running_o)
		else $error("stop ignored");
	a_uf_when_run: assert property (underflow_o |-> $past(running_o))
		else $error("underflow while stopped");
	a_irq_clear: assert property (rd_i && addr_i == ADDR_IRQ_STATUS && !underflow_o
		##1 !underflow_o [*2] |-> !irq_o) else $error("irq not cleared");
	a_run_cause: assert property ($rose(running_o) |-> $past(wr_i || tx_end_i || lfo_i))
		else $error("start without cause");
	a_stop_cause: assert property ($fell(running_o) |-> underflow_o || $past(any_ev))
		else $error("stop without cause");
	a_irq_cause: assert property ($rose(irq_o) |-> underflow_o || $past(underflow_o)
		|| $past(wr_i) || $past(wr_i, 2)) else $error("irq without cause");
endmodule // rft_monitor
bind rft_timer_one rft_monitor u_mon (.*);

// ---- test/rft_timer_one_bench.sv ----
// Self-checking bench for frame timer one: registers, count sources, modes.
// Assumes the bench alone drives every timer input; no other timers present.
`timescale 1ns/1ps
module rft_timer_one_bench
	import rft_pkg::*;
;
	logic       clk_i = 0, nrst_i = 0, wr = 0, rd = 0, rxf = 0, low_frequency_oscillator = 0;
	logic [7:0] ad = 0, wd = 0, t0l = 0, rdata_o;
	logic [5:0] ev = 0;
	logic       underflow_o, running_o, irq_o;
	int         error_cnt = 0, cmp_count = 0, ufc = 0, rl = 0, seed = 32'hE60F;
	rft_timer_one DUT (
		.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
		.tick_fast_i(ev[0]), .tick_slow_i(ev[1]), .t0_underflow_i(ev[2]), .t2_underflow_i(ev[3]),
		.t0_count_low_i(t0l), .tx_end_i(ev[4]), .rx_bit_i(ev[5]), .rx_frame_i(rxf),
		.lfo_i(low_frequency_oscillator), .rdata_o(rdata_o), .underflow_o(underflow_o), .running_o(running_o),
		.irq_o(irq_o));
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (underflow_o === 1'b1) ufc++;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd <= 1'b1;
		ad <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, e);
	endtask
	task automatic pulse(input int n, input logic [5:0] m);
		repeat (n) begin
			@(posedge clk_i);
			ev <= m;
			@(posedge clk_i);
			ev <= 6'h00;
		end
	endtask
	task automatic run_is(input logic e);
		@(negedge clk_i);
		chk(running_o, e);
	endtask
	task automatic cnt_is(input int c);
		// Only called while no frame is received
		rd_reg(ADDR_T1_CNT_HI, 8'(c >> 8));
		rd_reg(ADDR_T1_CNT_LO, 8'(c));
	endtask
	task automatic start(input logic [7:0] ctl, input int r);
		rl = r;
		wr_reg(ADDR_T1_RLD_HI, 8'(r >> 8));
		wr_reg(ADDR_T1_RLD_LO, 8'(r));
		wr_reg(ADDR_T1_CTRL, ctl);
		wr_reg(ADDR_TIMER_CTRL, 8'h22);
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		t0l <= 8'($random(seed));
		rd_reg(ADDR_T1_CNT_HI, 8'h00);
		rd_reg(8'h40, 8'h00);
		wr_reg(ADDR_T1_CTRL, 8'hFF);
		rd_reg(ADDR_T1_CTRL, CTRL_WR_MASK);
		rd_reg(ADDR_T0_CNT_LO, t0l);
		wr_reg(ADDR_TIMER_CTRL, 8'h20);
		run_is(1'b0);
		// Other sources pulse too, so a wrong select shows in the count
		for (int s = 0; s < 4; s++) begin
			start(8'(s), ($random(seed) & 255) + 8);
			pulse(3, 6'h0F ^ 6'(1 << s));
			pulse(5, 6'(1 << s));
			cnt_is(rl - 5);
		end
		wr_reg(ADDR_T1_RLD_HI, 8'h7F);
		pulse(1, 6'h08);
		cnt_is(rl - 6);
		wr_reg(ADDR_TIMER_CTRL, 8'h22);
		cnt_is(16'h7F00 | rl[7:0]);
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		start(8'h00, 2);
		ufc = 0;
		pulse(3, 6'h01);
		repeat (2) @(negedge clk_i);
		chk(16'(ufc), 16'h0001);
		chk(running_o, 1'b0);
		chk(irq_o, 1'b1);
		rd_reg(ADDR_IRQ_STATUS, 8'h01);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1'b0);
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		start(8'h08, 2);
		pulse(3, 6'h01);
		run_is(1'b1);
		chk(irq_o, 1'b0);
		cnt_is(2);
		rd_reg(ADDR_IRQ_STATUS, 8'h01);
		wr_reg(ADDR_T1_CTRL, 8'h00);
		wr_reg(ADDR_TIMER_CTRL, 8'h02);
		pulse(1, 6'h10);
		run_is(1'b0);
		wr_reg(ADDR_T1_CTRL, 8'h10);
		pulse(1, 6'h10);
		run_is(1'b1);
		start(8'h80, 9);
		rxf <= 1'b1;
		pulse(3, 6'h20);
		run_is(1'b1);
		pulse(1, 6'h20);
		run_is(1'b0);
		rxf <= 1'b0;
		wr_reg(ADDR_T1_CTRL, 8'hA0);
		low_frequency_oscillator <= 1'b1;
		@(posedge clk_i);
		run_is(1'b1);
		rxf <= 1'b1;
		pulse(4, 6'h20);
		run_is(1'b1);
		rxf <= 1'b0;
		low_frequency_oscillator <= 1'b0;
		@(posedge clk_i);
		low_frequency_oscillator <= 1'b1;
		@(posedge clk_i);
		run_is(1'b0);
		// Trimming without underflow stops silently, with underflow it flags
		start(8'h20, 1);
		ufc = 0;
		pulse(2, 6'h01);
		repeat (2) @(negedge clk_i);
		chk(16'(ufc), 16'h0000);
		chk(running_o, 1'b0);
		start(8'h30, 1);
		ufc = 0;
		pulse(2, 6'h01);
		repeat (2) @(negedge clk_i);
		chk(16'(ufc), 16'h0001);
		finish_test();
	end
endmodule // rft_timer_one_bench
